// *** hdl/cmd_defines.svh ***
// constants for the remote command interpreter: offsets, fields, resets
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

// ------------------------------------------------------------------
// register word offsets (byte address = 4 * offset)
// ------------------------------------------------------------------
`define OFF_IFACE 4'h0
`define OFF_KEY 4'h1
`define OFF_LOCK 4'h2
`define OFF_HOLD 4'h3
`define OFF_HOLD_RESET 4'h4
`define OFF_MODE 4'h5
`define OFF_OP_COND 4'h6
`define OFF_OP_MASK 4'h7
`define OFF_OP_LATCH 4'h8
`define OFF_PEAK_CLEAR 4'h9
`define OFF_PROBE 4'hA
`define OFF_RAMP 4'hB
`define OFF_RANGE 4'hC
`define OFF_MEAS 4'hD
`define OFF_FAST 4'hE
`define OFF_MINMAX 4'hF

// ------------------------------------------------------------------
// reset values and the fast count limit
// ------------------------------------------------------------------
`define RST_TERM 2'h0
`define RST_EOI_DIS 1'b0
`define RST_ADDR 5'h04
`define RST_KEY 8'h01
`define RST_RANGE 3'h1
`define RST_MEAS 3'h1
`define RST_SUB 2'h1
`define RST_FAST 17'h0_0001
`define FAST_MAX 17'h1_869F

// ------------------------------------------------------------------
// field limits and codes
// ------------------------------------------------------------------
`define ADDR_MIN 5'h01
`define ADDR_MAX 5'h1E
`define TERM_NONE 2'h3
`define LOCK_MAX 10'h3E7
`define MODE_RMS 3'h2
`define PEAK_PULSE 2'h2

`endif

// *** hdl/cmd_pkg.sv ***
// types shared by the remote command interpreter
package cmd_pkg;

    typedef struct packed {
        logic [1:0] term;
        logic eoi_dis;
        logic [4:0] addr;
    } iface_s;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] dc_res;
        logic [1:0] rms_band;
        logic [1:0] peak_sub;
        logic [1:0] peak_disp;
    } meas_s;

    typedef enum logic [1:0] {
        IF_LOCAL,
        IF_REMOTE,
        IF_LOCKOUT
    } if_mode_e;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_e;

endpackage : cmd_pkg

// *** hdl/remote_cmd.sv ***
// remote command interpreter: settings, status and hold logic
`timescale 1ns/1ps
`default_nettype none
`include "cmd_defines.svh"

module remote_cmd #(
    parameter int OP_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic [1:0] response_o,
    // link side
    input wire logic cmd_end_i,
    output logic [1:0] term_sel_o,
    output logic eoi_en_o,
    output logic [4:0] bus_addr_o,
    // front panel
    input wire logic key_valid_i,
    input wire logic [7:0] key_code_i,
    output logic panel_locked_o,
    output logic [1:0] if_mode_o,
    // measurement engine
    input wire logic [31:0] field_i,
    input wire logic [31:0] freq_i,
    input wire logic ramping_i,
    input wire logic [OP_W-1:0] op_cond_i,
    input wire logic [31:0] pos_peak_i,
    input wire logic [31:0] neg_peak_i,
    output logic peak_clear_o,
    output logic field_corr_o,
    output logic temp_corr_o,
    output logic [2:0] range_o,
    output logic [10:0] meas_o,
    output logic [1:0] hold_disp_o,
    output logic [16:0] fast_count_o,
    output logic fast_start_o,
    output logic op_summary_o
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    cmd_pkg::bus_state_e state_q;
    logic [3:0] idx;
    logic mapped;
    logic wr_go;
    logic rd_go;
    assign idx = address_i[5:2];
    assign mapped = (address_i[1:0] == 2'h0);
    assign wr_go = write_i && (state_q == cmd_pkg::BUS_IDLE) && mapped;
    assign rd_go = read_i && (state_q == cmd_pkg::BUS_IDLE) && mapped;

    // one wait cycle, then answer: keeps read side effects single-shot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= cmd_pkg::BUS_IDLE;
        end else if (state_q == cmd_pkg::BUS_ANSWER) begin
            state_q <= cmd_pkg::BUS_IDLE;
        end else if (read_i || write_i) begin
            state_q <= cmd_pkg::BUS_ANSWER;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            waitrequest_o <= 1'b1;
        end else begin
            waitrequest_o <= !((read_i || write_i)
                && state_q == cmd_pkg::BUS_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // interface settings
    // ------------------------------------------------------------------
    cmd_pkg::iface_s pend_q;
    logic pend_valid_q;
    logic [1:0] w_term;
    logic w_eoi_dis;
    logic [4:0] w_addr;
    logic if_ok;
    assign w_term = writedata_i[1:0];
    assign w_eoi_dis = writedata_i[2];
    assign w_addr = writedata_i[12:8];
    assign if_ok = (w_addr >= `ADDR_MIN) && (w_addr <= `ADDR_MAX)
        && !((w_term == `TERM_NONE) && w_eoi_dis);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= '{`RST_TERM, `RST_EOI_DIS, `RST_ADDR};
            pend_valid_q <= 1'b0;
        end else if (wr_go && idx == `OFF_IFACE && if_ok) begin
            pend_q <= '{w_term, w_eoi_dis, w_addr};
            pend_valid_q <= 1'b1;
        end else if (cmd_end_i) begin
            pend_valid_q <= 1'b0;
        end
    end

    // switch only when the current command has ended
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_sel_o <= `RST_TERM;
            eoi_en_o <= 1'b1;
            bus_addr_o <= `RST_ADDR;
        end else if (pend_valid_q && cmd_end_i) begin
            term_sel_o <= pend_q.term;
            eoi_en_o <= !pend_q.eoi_dis;
            bus_addr_o <= pend_q.addr;
        end
    end

    // ------------------------------------------------------------------
    // keypad and lock
    // ------------------------------------------------------------------
    logic [7:0] key_q;
    logic [9:0] lock_code_q;
    // new key wins over the clear by a query
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_q <= `RST_KEY;
        end else if (key_valid_i) begin
            key_q <= key_code_i;
        end else if (rd_go && idx == `OFF_KEY) begin
            key_q <= 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            panel_locked_o <= 1'b0;
            lock_code_q <= 10'h000;
        end else if (wr_go && idx == `OFF_LOCK
            && writedata_i[9:0] <= `LOCK_MAX) begin
            lock_code_q <= writedata_i[9:0];
            panel_locked_o <= writedata_i[16];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            if_mode_o <= cmd_pkg::IF_LOCAL;
        end else if (wr_go && idx == `OFF_MODE
            && writedata_i[1:0] <= cmd_pkg::IF_LOCKOUT) begin
            if_mode_o <= writedata_i[1:0];
        end
    end

    // ------------------------------------------------------------------
    // extreme hold
    // ------------------------------------------------------------------
    logic hold_on_q;
    logic [1:0] hold_cmp_q;
    logic [1:0] hold_disp_q;
    logic [31:0] min_q;
    logic [31:0] max_q;
    logic [31:0] mag;
    logic above;
    logic below;
    assign mag = {1'b0, field_i[30:0]};

    // absolute or signed compare of float words
    always_comb begin
        above = 1'b0;
        below = 1'b0;
        if (hold_cmp_q == 2'h1) begin
            above = mag > {1'b0, max_q[30:0]};
            below = mag < {1'b0, min_q[30:0]};
        end else begin
            above = field_i[31] ? (max_q[31] && field_i[30:0] < max_q[30:0])
                : (max_q[31] || field_i[30:0] > max_q[30:0]);
            below = field_i[31] ? (!min_q[31] || field_i[30:0] > min_q[30:0])
                : (!min_q[31] && field_i[30:0] < min_q[30:0]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_on_q <= 1'b0;
            hold_cmp_q <= 2'h1;
            hold_disp_q <= 2'h1;
        end else if (wr_go && idx == `OFF_HOLD && writedata_i[9:8] != 2'h0
            && writedata_i[9:8] != 2'h3 && writedata_i[17:16] != 2'h0) begin
            hold_on_q <= writedata_i[0];
            hold_cmp_q <= writedata_i[9:8];
            hold_disp_q <= writedata_i[17:16];
        end
    end

    // zero means the normal line-two choice stands
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_disp_o <= 2'h0;
        end else begin
            hold_disp_o <= hold_on_q ? hold_disp_q : 2'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            min_q <= 32'h0000_0000;
            max_q <= 32'h0000_0000;
        end else if (wr_go && idx == `OFF_HOLD_RESET) begin
            min_q <= field_i;
            max_q <= field_i;
        end else if (hold_on_q) begin
            if (above) begin
                max_q <= field_i;
            end
            if (below) begin
                min_q <= field_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // operational status
    // ------------------------------------------------------------------
    logic [OP_W-1:0] op_mask_q;
    logic [OP_W-1:0] op_latch_q;
    logic latch_rd;
    assign latch_rd = rd_go && idx == `OFF_OP_LATCH;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_mask_q <= '0;
        end else if (wr_go && idx == `OFF_OP_MASK) begin
            op_mask_q <= writedata_i[OP_W-1:0];
        end
    end

    // clear on read; new detection wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_latch_q <= '0;
        end else begin
            op_latch_q <= (latch_rd ? '0 : op_latch_q) | op_cond_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_summary_o <= 1'b0;
        end else begin
            op_summary_o <= |(op_latch_q & op_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // measurement settings
    // ------------------------------------------------------------------
    cmd_pkg::meas_s w_meas;
    logic meas_ok;
    assign w_meas = writedata_i[10:0];
    assign meas_ok = w_meas.mode >= 3'h1 && w_meas.mode <= 3'h3
        && w_meas.rms_band != 2'h0 && w_meas.peak_sub != 2'h0
        && w_meas.peak_sub != 2'h3 && w_meas.peak_disp != 2'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meas_o <= {`RST_MEAS, 2'h3, 2'h1, `RST_SUB, 2'h1};
        end else if (wr_go && idx == `OFF_MEAS && meas_ok) begin
            meas_o <= w_meas;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            peak_clear_o <= 1'b0;
        end else begin
            peak_clear_o <= wr_go && idx == `OFF_PEAK_CLEAR
                && meas_o[3:2] == `PEAK_PULSE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            field_corr_o <= 1'b0;
            temp_corr_o <= 1'b0;
        end else if (wr_go && idx == `OFF_PROBE) begin
            field_corr_o <= writedata_i[0];
            temp_corr_o <= writedata_i[8];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            range_o <= `RST_RANGE;
        end else if (wr_go && idx == `OFF_RANGE
            && writedata_i[2:0] >= 3'h1 && writedata_i[2:0] <= 3'h5) begin
            range_o <= writedata_i[2:0];
        end
    end

    // count 1..99999 starts the binary block readout
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_count_o <= `RST_FAST;
            fast_start_o <= 1'b0;
        end else begin
            fast_start_o <= 1'b0;
            if (wr_go && idx == `OFF_FAST && writedata_i[16:0] != 17'h0_0000
                && writedata_i[16:0] <= `FAST_MAX
                && writedata_i[31:17] == 15'h0000) begin
                fast_count_o <= writedata_i[16:0];
                fast_start_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [31:0] rd_d;
    // queries return stored settings in command field order
    always_comb begin
        rd_d = 32'h0000_0000;
        case (idx)
            `OFF_IFACE: rd_d = {19'h0_0000, bus_addr_o, 5'h00,
                !eoi_en_o, term_sel_o};
            `OFF_KEY: rd_d = {24'h00_0000, key_q};
            `OFF_LOCK: rd_d = {15'h0000, panel_locked_o, 6'h00, lock_code_q};
            `OFF_HOLD: rd_d = {14'h0000, hold_disp_q, 6'h00, hold_cmp_q,
                7'h00, hold_on_q};
            `OFF_MODE: rd_d = {30'h0000_0000, if_mode_o};
            `OFF_OP_COND: rd_d = 32'(op_cond_i);
            `OFF_OP_MASK: rd_d = 32'(op_mask_q);
            `OFF_OP_LATCH: rd_d = 32'(op_latch_q);
            `OFF_PROBE: rd_d = {23'h00_0000, temp_corr_o, 7'h00, field_corr_o};
            `OFF_RAMP: rd_d = {31'h0000_0000, ramping_i};
            `OFF_RANGE: rd_d = {29'h0000_0000, range_o};
            // bit 11 flags RMS mode; high half reads zero, frequency is at the hold-reset offset
            `OFF_MEAS: rd_d = {16'h0000, 4'h0,
                meas_o[10:8] == `MODE_RMS, meas_o};
            `OFF_FAST: rd_d = {15'h0000, fast_count_o};
            `OFF_MINMAX: rd_d = address_i[0] ? max_q : min_q;
            `OFF_PEAK_CLEAR: rd_d = pos_peak_i ^ neg_peak_i;
            `OFF_HOLD_RESET: rd_d = (meas_o[10:8] == `MODE_RMS) ? freq_i
                : 32'h0000_0000;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_o <= 32'h0000_0000;
            response_o <= 2'h0;
        end else if ((read_i || write_i) && state_q == cmd_pkg::BUS_IDLE) begin
            readdata_o <= (read_i && mapped) ? rd_d : 32'h0000_0000;
            // unaligned address answers slave error
            response_o <= mapped ? 2'h0 : 2'h2;
        end
    end

endmodule : remote_cmd
`default_nettype wire

// *** sim/remote_cmd_monitor.sv ***
// port-level assertion checker for the remote command interpreter
`timescale 1ns/1ps
`default_nettype none

module remote_cmd_monitor #(
    parameter int OP_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register bus
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire logic [1:0] response_o,
    // link, panel and engine
    input wire logic cmd_end_i,
    input wire logic [1:0] term_sel_o,
    input wire logic eoi_en_o,
    input wire logic [4:0] bus_addr_o,
    input wire logic [1:0] if_mode_o,
    input wire logic ramping_i,
    input wire logic [OP_W-1:0] op_cond_i,
    input wire logic peak_clear_o,
    input wire logic [2:0] range_o,
    input wire logic [10:0] meas_o,
    input wire logic [16:0] fast_count_o,
    input wire logic fast_start_o,
    input wire logic op_summary_o
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    answer_once_a: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not a single cycle");
    term_eoi_a: assert property (
        term_sel_o == 2'h3 |-> eoi_en_o)
        else $error("no terminator while end-or-identify off");
    addr_range_a: assert property (
        bus_addr_o >= 5'h01 && bus_addr_o <= 5'h1E)
        else $error("bus address outside 1 to 30");
    iface_hold_a: assert property (
        !cmd_end_i |=> $stable({term_sel_o, eoi_en_o, bus_addr_o}))
        else $error("interface changed without a terminator");
    range_ok_a: assert property (
        range_o inside {[3'h1:3'h5]})
        else $error("range code out of 1 to 5");
    mode_ok_a: assert property (
        if_mode_o <= 2'h2)
        else $error("interface mode code invalid");
    meas_ok_a: assert property (
        meas_o[10:8] inside {[3'h1:3'h3]} && meas_o[5:4] != 2'h0)
        else $error("measurement or band code invalid");
    sub_ok_a: assert property (
        meas_o[3:2] inside {2'h1, 2'h2} && meas_o[1:0] != 2'h0)
        else $error("peak sub-mode or display code invalid");
    fast_ok_a: assert property (
        fast_count_o inside {[17'h0_0001:17'h1_869F]})
        else $error("fast reading count out of range");
    peak_pulse_a: assert property (
        peak_clear_o |-> meas_o[3:2] == 2'h2 ##1 !peak_clear_o)
        else $error("peak clear outside pulse sub-mode");
    freq_gate_a: assert property (
        read_i && waitrequest_o && address_i == 6'h10 && meas_o[10:8] != 3'h2
        |=> readdata_o == 32'h0000_0000)
        else $error("frequency returned outside rms mode");
    cond_read_a: assert property (
        read_i && waitrequest_o && address_i == 6'h18
        |=> readdata_o == 32'($past(op_cond_i)))
        else $error("condition read differs from inputs");
    ramp_read_a: assert property (
        read_i && waitrequest_o && address_i == 6'h2C
        |=> readdata_o == {31'h0000_0000, $past(ramping_i)})
        else $error("ramp status read wrong");

    cover property (peak_clear_o);
    cover property (fast_start_o);
    cover property ($fell(waitrequest_o) && response_o == 2'h2);
    cover property (op_summary_o);
endmodule : remote_cmd_monitor

`default_nettype wire

// *** sim/host_link_model.sv ***
// link-side host model: ends the command in progress with its terminator
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench request and terminator strobe
    input wire logic end_req_i,
    output logic cmd_end_o
);
    // one terminator per command
    // a held request still yields single pulses, never a level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_end_o <= 1'b0;
        end else begin
            cmd_end_o <= end_req_i && !cmd_end_o;
        end
    end
endmodule : host_link_model

`default_nettype wire

// *** sim/test_remote_cmd.sv ***
// self-checking bench for the remote command interpreter
`timescale 1ns/1ps
`default_nettype none

module test_remote_cmd;
    localparam int OP_W = 8;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] address_i = 6'h00;
    logic read_i = 1'b0, write_i = 1'b0, key_valid_i = 1'b0;
    logic ramping_i = 1'b0, end_req = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic [3:0] byteenable_i = 4'hF;
    logic [7:0] key_code_i = 8'h00;
    logic [31:0] field_i = 32'h4120_0000, freq_i = 32'h4248_0000;
    logic [31:0] pos_peak_i = 32'h3F80_0000, neg_peak_i = 32'hBF80_0000;
    logic [OP_W-1:0] op_cond_i = '0;
    logic [31:0] readdata_o, rdata;
    logic [1:0] response_o, rresp, term_sel_o, if_mode_o, hold_disp_o;
    logic waitrequest_o, cmd_end_i, eoi_en_o, panel_locked_o, peak_clear_o;
    logic field_corr_o, temp_corr_o, fast_start_o, op_summary_o;
    logic [4:0] bus_addr_o;
    logic [2:0] range_o;
    logic [10:0] meas_o;
    logic [16:0] fast_count_o;
    int num_errors = 0, checked = 0, n_peak = 0, n_fast = 0;

    remote_cmd #(.OP_W(OP_W)) dut (.*);
    host_link_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .end_req_i(end_req), .cmd_end_o(cmd_end_i));

    always #20 clk_i = ~clk_i;

    // one-cycle strobes are counted where they are sampled
    always @(posedge clk_i) begin
        if (peak_clear_o === 1'b1) n_peak++;
        if (fast_start_o === 1'b1) n_fast++;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] e,
            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    // request stays up until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        rdata = readdata_o;
        rresp = response_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (n >= 20) chk("waitrequest", 32'h0, 32'(waitrequest_o));
    endtask : bus

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        bus(1'b1, {i, 2'b00}, d);
    endtask : wr

    task automatic rd(input logic [3:0] i, input logic [31:0] e,
            input string name);
        bus(1'b0, {i, 2'b00}, 32'h0);
        chk(name, e, rdata);
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task automatic term_end;
        @(posedge clk_i);
        end_req <= 1'b1;
        @(posedge clk_i);
        end_req <= 1'b0;
        settle();
    endtask : term_end

    task automatic key_press(input logic [7:0] c);
        @(posedge clk_i);
        key_valid_i <= 1'b1;
        key_code_i <= c;
        @(posedge clk_i);
        key_valid_i <= 1'b0;
    endtask : key_press

    function automatic logic [31:0] mk(input logic [2:0] m,
            input logic [1:0] s);
        return {21'h0, m, 2'h3, 2'h2, s, 2'h3};
    endfunction : mk

    task automatic complete_run;
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("iface_rst", 32'h0000_0024, {term_sel_o, eoi_en_o, bus_addr_o});
        chk("meas_rst", 32'h0000_01D5, 32'(meas_o));
        chk("range_rst", 32'h1, 32'(range_o));
        chk("fast_rst", 32'h1, 32'(fast_count_o));
        rd(4'h1, 32'h1, "key_first");
        rd(4'h1, 32'h0, "key_none");
        key_press(8'h2A);
        key_press(8'h33);
        rd(4'h1, 32'h33, "key_last");
    endtask : t_reset

    task automatic t_iface;
        int t;
        for (t = 0; t < 3; t++) begin
            wr(4'h0, 32'h0000_0904 | 32'(t));
            settle();
            chk("term_held", t == 0 ? 0 : 32'(t - 1), 32'(term_sel_o));
            term_end();
            chk("term_new", 32'(t), 32'(term_sel_o));
        end
        chk("eoi_off", 32'h0, 32'(eoi_en_o));
        chk("addr_new", 32'h9, 32'(bus_addr_o));
        wr(4'h0, 32'h0000_0907);
        wr(4'h0, 32'h0000_0000);
        wr(4'h0, 32'h0000_1F00);
        term_end();
        rd(4'h0, 32'h0000_0906, "iface_keep");
        wr(4'h0, 32'h0000_1E03);
        term_end();
        chk("iface_top", 32'h0000_00FE, {term_sel_o, eoi_en_o, bus_addr_o});
        bus(1'b1, 6'h01, 32'h0);
        chk("resp_bad", 32'h2, 32'(rresp));
    endtask : t_iface

    task automatic t_lock_hold;
        int d;
        wr(4'h2, 32'h0001_03E7);
        wr(4'h2, 32'h0000_03E8);
        settle();
        chk("locked", 32'h1, 32'(panel_locked_o));
        rd(4'h2, 32'h0001_03E7, "lock_keep");
        for (d = 0; d < 4; d++) begin
            wr(4'h5, 32'(d));
            settle();
            chk("if_mode", d < 3 ? 32'(d) : 32'h2, 32'(if_mode_o));
        end
        for (d = 1; d < 4; d++) begin
            wr(4'h3, 32'(d << 16) | 32'h0000_0101);
            settle();
            chk("hold_disp", 32'(d), 32'(hold_disp_o));
        end
        wr(4'h3, 32'h0003_0301);
        rd(4'h3, 32'h0003_0101, "hold_keep");
        wr(4'h4, 32'h0);
        rd(4'hF, 32'h4120_0000, "min_load");
        // -20.0 is larger in magnitude, smaller only when signed
        field_i <= 32'hC1A0_0000;
        rd(4'hF, 32'h4120_0000, "min_abs");
        wr(4'h3, 32'h0001_0201);
        rd(4'hF, 32'hC1A0_0000, "min_signed");
        wr(4'h3, 32'h0001_0200);
        settle();
        chk("hold_off", 32'h0, 32'(hold_disp_o));
    endtask : t_lock_hold

    task automatic t_status;
        wr(4'h7, 32'h2);
        @(posedge clk_i);
        op_cond_i <= 8'h05;
        rd(4'h6, 32'h5, "cond_sum");
        op_cond_i <= 8'h00;
        settle();
        chk("summary_masked", 32'h0, 32'(op_summary_o));
        wr(4'h7, 32'h4);
        settle();
        chk("summary_on", 32'h1, 32'(op_summary_o));
        rd(4'h8, 32'h5, "latch_read");
        rd(4'h8, 32'h0, "latch_clear");
        rd(4'h7, 32'h4, "mask_read");
    endtask : t_status

    task automatic t_meas;
        int m;
        wr(4'hD, mk(3'h3, 2'h1));
        wr(4'h9, 32'h0);
        settle();
        chk("peak_periodic", 32'h0, 32'(n_peak));
        for (m = 1; m < 4; m++) begin
            wr(4'hD, mk(3'(m), 2'h2));
            rd(4'h4, m == 2 ? freq_i : 0, "freq_gate");
            chk("meas_mode", 32'(m), 32'(meas_o[10:8]));
        end
        wr(4'hD, mk(3'h0, 2'h1));
        rd(4'hD, mk(3'h3, 2'h2), "meas_keep");
        wr(4'h9, 32'h0);
        settle();
        chk("peak_pulse", 32'h1, 32'(n_peak));
        for (m = 0; m < 4; m++) begin
            wr(4'hA, 32'(m[1] << 8) | 32'(m[0]));
            settle();
            chk("field_corr", 32'(m[0]), 32'(field_corr_o));
            chk("temp_corr", 32'(m[1]), 32'(temp_corr_o));
        end
        for (m = 0; m < 7; m++) begin
            wr(4'hC, 32'(m));
            settle();
            chk("range", m == 0 ? 1 : m > 5 ? 5 : 32'(m), 32'(range_o));
        end
        @(posedge clk_i);
        ramping_i <= 1'b1;
        rd(4'hB, 32'h1, "ramping");
    endtask : t_meas

    task automatic t_fast;
        wr(4'hE, 32'h0001_869F);
        wr(4'hE, 32'h0000_0000);
        wr(4'hE, 32'h0001_86A0);
        settle();
        chk("fast_count", 32'h0001_869F, 32'(fast_count_o));
        chk("fast_start", 32'h1, 32'(n_fast));
    endtask : t_fast

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        t_reset();
        t_iface();
        t_lock_hold();
        t_status();
        t_meas();
        t_fast();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule : test_remote_cmd

bind remote_cmd remote_cmd_monitor #(.OP_W(OP_W)) u_mon (.*);

`default_nettype wire
